// ===== rtl/cal_result_if.sv
`timescale 1ns/1ps
`default_nettype none
// Carries one calibration result to the store and both stored results back to the sequencer
interface cal_result_if;
    logic       wr_first;
    logic       wr_second;
    logic [3:0] pump_in;
    logic [3:0] pump_first;
    logic [3:0] pump_second;
    modport seq   (output wr_first, output wr_second, output pump_in,
                   input pump_first, input pump_second);
    modport store (input wr_first, input wr_second, input pump_in,
                   output pump_first, output pump_second);
endinterface : cal_result_if
`default_nettype wire

// ===== rtl/cal_result_store.sv
`timescale 1ns/1ps
`default_nettype none
module cal_result_store
(
    input  wire logic   ref_clk,
    cal_result_if.store res
);
    logic [3:0] pump_first;
    logic [3:0] pump_second;
    logic [3:0] next_pump_first;
    logic [3:0] next_pump_second;

    // Results survive soft reset; only the power-on reset rst clears them [RL2] [RL10]
    always_comb
    begin
        next_pump_first  = res.wr_first  ? res.pump_in : pump_first;
        next_pump_second = res.wr_second ? res.pump_in : pump_second;
    end

    always_ff @(posedge ref_clk)
    begin
        pump_first  <= next_pump_first;
        pump_second <= next_pump_second;
    end

    assign res.pump_first  = pump_first;
    assign res.pump_second = pump_second;
endmodule : cal_result_store
`default_nettype wire

// ===== rtl/pll_cal_pkg.sv
`default_nettype none
package pll_cal_pkg;
    // Wait-time code, lock pin source codes and field reset values
    localparam logic [1:0] WAIT_CODE_RESET   = 2'h0;
    localparam logic [3:0] LOCK_SRC_LOCKED   = 4'h2;
    localparam logic [3:0] LOCK_SRC_CAL_DONE = 4'h5;
    localparam logic [2:0] VTARGET_RESET     = 3'h5;
    localparam logic [3:0] PUMP_RESET        = 4'h0;
    localparam logic [3:0] BIAS_RESET        = 4'h8;
    // Calibration durations at the lowest reference, in ms, per wait code
    localparam int CAL_MS_00 = 49;
    localparam int CAL_MS_01 = 60;
    localparam int CAL_MS_10 = 71;
    localparam int CAL_MS_11 = 109;
    localparam int CLK_HZ    = 25_000_000;
    localparam int CYC_PER_MS = CLK_HZ / 1000;
    // Lock filter, in cycles of ref_clk
    localparam int LOCK_FILT_CYC = 4;

    typedef enum logic [1:0] {
        CAL_IDLE  = 2'b00,
        CAL_FIRST = 2'b01,
        CAL_SECND = 2'b10
    } cal_state_e;
endpackage : pll_cal_pkg
`default_nettype wire

// ===== rtl/pll_calibration_power_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
// How it works
// (RL1) Start bit launches automatic calibration of VCO range and pump current.
// (RL2) Calibration results held internally while powered; soft reset keeps them.
// (RL3) Host recalibrates after 0.25 V supply drop or 40 C shift.
// (RL4) Three-bit field sets the VCO control voltage that calibration targets.
// (RL5) Calibration-done flag rises when calibration finishes.
// (RL6) Two-bit wait code selects run length, 49 to 109 ms at lowest reference.
// (RL7) Host should use wait code 11 and the highest reference.
// (RL8) Lock pin shows calibration-done when selector is 0101.
// (RL9) Locked flag reported; lock pin shows it when selector is 0010.
// (RL10) Separate results per frequency register; shared only under strict conditions.
// (RL11) Dual bit 0 calibrates each register apart, 1 shares one result.
// (RL12) Host should prefer separate calibration.
// (RL13) Host recalibrates until the locked flag shows lock.
// (RL14) Host waits PLL turn-on time, 3200 to 700 us, after power-up.
// (RL15) Host allows PLL lock time, 1300 to 14 us, on RX/TX switch.
// (RL16) Separate VCO bias settings kept for each frequency register.
// (RL17) Separate power bits for receive, transmit, synthesizer and oscillator.
// (RL18) Host clears active-low soft reset bit on first power-up.
// (RL19) Configuration bits accepted in any order; defaults apply otherwise.
// (RL20) Host power-up order: reset, init, RX, calibrate, TX, calibrate.
// (RL21) Host leaves power-down by wake-up step then mode setup step.
// (RL22) Host keeps serial select high or floating in power-down.
// (RL23) Chosen four-bit pump current readable from the second status register.
// (RL24) Done flag clears on a new start, sets again on completion.
// (RL25) Start acts as a one-run trigger on the selected register.
module pll_calibration_power_sequencer
#(
    parameter int CYC_PER_MS = pll_cal_pkg::CYC_PER_MS
)
(
    input  wire logic       ref_clk,
    input  wire logic       rst,
    input  wire logic       soft_reset_n,
    input  wire logic       cal_start,
    input  wire logic       cal_dual,
    input  wire logic [1:0] cal_wait,
    input  wire logic [2:0] vco_voltage_target,
    input  wire logic [3:0] lock_select,
    input  wire logic       freq_select,
    input  wire logic [3:0] osc_bias_first,
    input  wire logic [3:0] osc_bias_second,
    input  wire logic       rx_power_en,
    input  wire logic       tx_power_en,
    input  wire logic       synth_power_en,
    input  wire logic       xosc_power_en,
    input  wire logic       pll_lock_raw,
    input  wire logic [3:0] pump_measured,
    output logic            cal_done,
    output logic            pll_locked_flag,
    output logic [3:0]      pump_current_code,
    output logic [7:0]      second_status_reg,
    output logic [2:0]      cal_vtarget,
    output logic [3:0]      osc_bias,
    output logic            rx_on,
    output logic            tx_on,
    output logic            synth_on,
    output logic            xosc_on,
    output logic            cal_busy,
    output logic            lock_pin
);
    // Refuse rates whose longest run cannot be counted in a signed 32-bit int
    if (CYC_PER_MS < 1 || CYC_PER_MS > 19_000_000)
    begin : g_bad_rate
        $error("CYC_PER_MS out of range");
    end

    ////////////////////////////////////////////////////////////////////////
    // Synchronisers for the analog lock and start inputs
    logic [1:0] lock_sync;
    logic [1:0] start_sync;
    logic       start_prev;
    logic [1:0] next_lock_sync;
    logic [1:0] next_start_sync;

    always_comb
    begin
        next_lock_sync  = {lock_sync[0], pll_lock_raw};
        next_start_sync = {start_sync[0], cal_start};
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            lock_sync  <= 2'h0;
            start_sync <= 2'h0;
            start_prev <= 1'b0;
        end
        else
        begin
            lock_sync  <= next_lock_sync;
            start_sync <= next_start_sync;
            start_prev <= start_sync[1];
        end
    end

    wire start_pulse = start_sync[1] & ~start_prev;

    ////////////////////////////////////////////////////////////////////////
    // Calibration length in cycles per wait code
    function automatic logic [31:0] wait_cycles(input logic [1:0] code);
        int ms;
        unique case (code)
            2'b00: ms = pll_cal_pkg::CAL_MS_00;
            2'b01: ms = pll_cal_pkg::CAL_MS_01;
            2'b10: ms = pll_cal_pkg::CAL_MS_10;
            2'b11: ms = pll_cal_pkg::CAL_MS_11;
        endcase
        return 32'(ms * CYC_PER_MS);
    endfunction : wait_cycles

    ////////////////////////////////////////////////////////////////////////
    // Calibration sequencer
    cal_result_if res ();
    cal_result_store u_store (.ref_clk(ref_clk), .res(res));

    pll_cal_pkg::cal_state_e state;
    pll_cal_pkg::cal_state_e next_state;
    logic [31:0] timer;
    logic [31:0] next_timer;
    logic        done;
    logic        next_done;
    logic        dual;
    logic        next_dual;
    logic        target;
    logic        next_target;

    // Which register the current run trains
    wire run_second = (state == pll_cal_pkg::CAL_SECND) ? 1'b1 : target;

    always_comb
    begin
        next_state  = state;
        next_timer  = timer;
        next_done   = done;
        next_dual   = dual;
        next_target = target;
        res.wr_first  = 1'b0;
        res.wr_second = 1'b0;
        res.pump_in   = pump_measured;
        unique case (state)
            pll_cal_pkg::CAL_IDLE:
            begin
                if (start_pulse && soft_reset_n)
                begin
                    next_state  = pll_cal_pkg::CAL_FIRST;   // [RL1] [RL25]
                    next_timer  = wait_cycles(cal_wait);    // [RL6]
                    next_done   = 1'b0;                     // [RL24]
                    next_dual   = cal_dual;
                    next_target = freq_select;
                end
            end
            pll_cal_pkg::CAL_FIRST,
            pll_cal_pkg::CAL_SECND:
            begin
                if (timer > 32'h0000_0001)
                    next_timer = timer - 32'h0000_0001;
                else
                begin
                    // Dual run shares one result, else only the chosen one [RL11]
                    res.wr_first  = dual | ~run_second;     // [RL10]
                    res.wr_second = dual | run_second;      // [RL10]
                    next_state    = pll_cal_pkg::CAL_IDLE;
                    next_done     = 1'b1;                   // [RL5]
                end
            end
            default:
                next_state = pll_cal_pkg::CAL_IDLE;
        endcase
        if (!soft_reset_n)
        begin
            next_state = pll_cal_pkg::CAL_IDLE;
            next_done  = 1'b0;
        end
        // Power-on reset gives both stored results a known value [RL2]
        if (rst)
        begin
            res.wr_first  = 1'b1;
            res.wr_second = 1'b1;
            res.pump_in   = pll_cal_pkg::PUMP_RESET;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            state  <= pll_cal_pkg::CAL_IDLE;
            timer  <= 32'h0000_0000;
            done   <= 1'b0;
            dual   <= 1'b0;
            target <= 1'b0;
        end
        else
        begin
            state  <= next_state;
            timer  <= next_timer;
            done   <= next_done;
            dual   <= next_dual;
            target <= next_target;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Lock filter and registered outputs
    logic [2:0] lock_cnt;
    logic [2:0] next_lock_cnt;
    logic       next_lock_pin;
    logic [3:0] next_pump;

    always_comb
    begin
        if (!lock_sync[1])
            next_lock_cnt = 3'h0;
        else if (lock_cnt != 3'(pll_cal_pkg::LOCK_FILT_CYC))
            next_lock_cnt = lock_cnt + 3'h1;
        else
            next_lock_cnt = lock_cnt;
        next_pump = freq_select ? res.pump_second : res.pump_first;   // [RL23]
        unique case (lock_select)
            pll_cal_pkg::LOCK_SRC_CAL_DONE: next_lock_pin = done;        // [RL8]
            pll_cal_pkg::LOCK_SRC_LOCKED:   next_lock_pin = pll_locked_flag; // [RL9]
            default:                        next_lock_pin = 1'b0;
        endcase
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            lock_cnt          <= 3'h0;
            lock_pin          <= 1'b0;
            pump_current_code <= pll_cal_pkg::PUMP_RESET;
        end
        else
        begin
            lock_cnt          <= next_lock_cnt;
            lock_pin          <= next_lock_pin;
            pump_current_code <= next_pump;
        end
    end

    // Status and steering
    assign pll_locked_flag   = (lock_cnt == 3'(pll_cal_pkg::LOCK_FILT_CYC));   // [RL9]
    assign cal_done          = done;
    assign cal_busy          = (state != pll_cal_pkg::CAL_IDLE);
    assign second_status_reg = {4'h0, pump_current_code};            // [RL23]
    assign cal_vtarget       = vco_voltage_target;                   // [RL4] [RL19]
    // In a run the trained register's bias, when idle the selected one
    assign osc_bias          = (cal_busy ? run_second : freq_select)
                               ? osc_bias_second : osc_bias_first;   // [RL16]
    // Soft reset drops every section [RL17]
    assign rx_on    = soft_reset_n & rx_power_en;
    assign tx_on    = soft_reset_n & tx_power_en;
    assign synth_on = soft_reset_n & (synth_power_en | cal_busy);
    assign xosc_on  = soft_reset_n & (xosc_power_en | cal_busy);

    ////////////////////////////////////////////////////////////////////////
    // Checks
    property p_start_clears;
        @(posedge ref_clk) disable iff (rst)
        (state == pll_cal_pkg::CAL_IDLE && start_pulse && soft_reset_n) |=> !cal_done && cal_busy;
    endproperty
    a_start_clears: assert property (p_start_clears) else $error("start did not clear done"); // [RL24]

    property p_done_on_finish;
        @(posedge ref_clk) disable iff (rst)
        (cal_busy && timer == 32'h0000_0001 && soft_reset_n) |=> cal_done && !cal_busy;
    endproperty
    a_done_on_finish: assert property (p_done_on_finish) else $error("done missing"); // [RL5]

    property p_pin_done;
        @(posedge ref_clk) disable iff (rst)
        (lock_select == 4'h5) |=> (lock_pin == $past(cal_done));
    endproperty
    a_pin_done: assert property (p_pin_done) else $error("lock pin not done"); // [RL8]

    property p_pin_lock;
        @(posedge ref_clk) disable iff (rst)
        (lock_select == 4'h2) |=> (lock_pin == $past(pll_locked_flag));
    endproperty
    a_pin_lock: assert property (p_pin_lock) else $error("lock pin not lock"); // [RL9]

    property p_lock_filter;
        @(posedge ref_clk) disable iff (rst)
        pll_lock_raw [*7] |-> pll_locked_flag;
    endproperty
    a_lock_filter: assert property (p_lock_filter) else $error("lock flag late"); // [RL9]

    property p_busy_length;
        @(posedge ref_clk) disable iff (rst)
        $rose(cal_busy) |->
            (timer >= 32'(pll_cal_pkg::CAL_MS_00 * CYC_PER_MS)) ##0 cal_busy [*2];
    endproperty
    a_busy_length: assert property (p_busy_length) else $error("run too short"); // [RL6]

    property p_result_kept;
        @(posedge ref_clk) disable iff (rst)
        (!res.wr_first && !res.wr_second) |=> $stable(res.pump_first) && $stable(res.pump_second);
    endproperty
    a_result_kept: assert property (p_result_kept) else $error("result changed"); // [RL2]

    property p_dual_both;
        @(posedge ref_clk) disable iff (rst)
        (cal_busy && dual && timer == 32'h0000_0001 && soft_reset_n)
            |-> res.wr_first && res.wr_second;
    endproperty
    a_dual_both: assert property (p_dual_both) else $error("dual not shared"); // [RL11]

    property p_power_bits;
        @(posedge ref_clk) disable iff (rst)
        !soft_reset_n |-> !rx_on && !tx_on && !synth_on && !xosc_on;
    endproperty
    a_power_bits: assert property (p_power_bits) else $error("power on in reset"); // [RL17]
endmodule : pll_calibration_power_sequencer
`default_nettype wire

// ===== tb/pll_analog_model.sv
`timescale 1ns/1ps
`default_nettype none
// Stand-in for the analog synthesizer behind the calibration logic
module pll_analog_model
#(
    parameter int LOCK_DLY = 10
)
(
    input  wire logic       ref_clk,
    input  wire logic       rst,
    input  wire logic       synth_on,
    input  wire logic       cal_busy,
    input  wire logic [2:0] vtarget,
    output logic            pll_lock_raw,
    output logic [3:0]      pump_measured
);
    int         cnt;
    logic [3:0] pat;
    // Lock settles only while the synthesizer runs outside a calibration
    // LOCK_DLY stands for the turn-on and switch lock time
    always_ff @(posedge ref_clk)
    begin
        pat <= rst ? 4'h0 : pat + 4'h7;
        if (rst || !synth_on || cal_busy)
            cnt <= 0;
        else if (cnt < LOCK_DLY)
            cnt <= cnt + 1;
    end
    assign pll_lock_raw  = (cnt == LOCK_DLY);
    // Measurement valid only in a run; a moving pattern elsewhere
    assign pump_measured = cal_busy ? ({1'b0, vtarget} + 4'h3) : pat;
endmodule : pll_analog_model
`default_nettype wire

// ===== tb/pll_calibration_power_sequencer_tb.sv
`timescale 1ns/1ps
`default_nettype none
module pll_calibration_power_sequencer_tb;
    localparam int CYC = 2;
    typedef struct {int cyc; logic [3:0] pump; logic lpin;} exp_s;
    logic       ref_clk, rst, soft_reset_n, cal_start, cal_dual, freq_select, pend, done_q;
    logic       rx_power_en, tx_power_en, synth_power_en, xosc_power_en, pll_lock_raw;
    logic       cal_done, pll_locked_flag, rx_on, tx_on, synth_on, xosc_on, cal_busy, lock_pin;
    logic [1:0] cal_wait;
    logic [2:0] vco_voltage_target, cal_vtarget, vt;
    logic [3:0] lock_select, osc_bias_first, osc_bias_second, osc_bias;
    logic [3:0] pump_measured, pump_current_code, last_pump;
    logic [7:0] second_status_reg;
    int         err_count, check_count, cycles, busy_cnt, n, i, w;
    exp_s       exp_q[$];
    exp_s       e;
    ////////////////////////////////////////////////////////////////////////
    pll_calibration_power_sequencer #(.CYC_PER_MS(CYC)) dut_u (.ref_clk(ref_clk), .rst(rst),
        .soft_reset_n(soft_reset_n), .cal_start(cal_start), .cal_dual(cal_dual),
        .cal_wait(cal_wait), .vco_voltage_target(vco_voltage_target),
        .lock_select(lock_select), .freq_select(freq_select),
        .osc_bias_first(osc_bias_first), .osc_bias_second(osc_bias_second),
        .rx_power_en(rx_power_en), .tx_power_en(tx_power_en),
        .synth_power_en(synth_power_en), .xosc_power_en(xosc_power_en),
        .pll_lock_raw(pll_lock_raw), .pump_measured(pump_measured), .cal_done(cal_done),
        .pll_locked_flag(pll_locked_flag), .pump_current_code(pump_current_code),
        .second_status_reg(second_status_reg), .cal_vtarget(cal_vtarget),
        .osc_bias(osc_bias), .rx_on(rx_on), .tx_on(tx_on), .synth_on(synth_on),
        .xosc_on(xosc_on), .cal_busy(cal_busy), .lock_pin(lock_pin));
    pll_analog_model model_u (.ref_clk(ref_clk), .rst(rst), .synth_on(synth_on),
        .cal_busy(cal_busy), .vtarget(cal_vtarget), .pll_lock_raw(pll_lock_raw),
        .pump_measured(pump_measured));
    ////////////////////////////////////////////////////////////////////////
    // Compare and count
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] expd);
        check_count++;
        if (seen !== expd)
        begin
            err_count++;
            $display("ERROR %s expected %0h seen %0h", name, expd, seen);
        end
    endtask : chk
    // Final verdict
    task automatic print_verdict();
        if (err_count == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : print_verdict
    // Run length per wait code
    function automatic int cyc_of(input logic [1:0] c);
        case (c)
            2'h0: return pll_cal_pkg::CAL_MS_00 * CYC;
            2'h1: return pll_cal_pkg::CAL_MS_01 * CYC;
            2'h2: return pll_cal_pkg::CAL_MS_10 * CYC;
            default: return pll_cal_pkg::CAL_MS_11 * CYC;
        endcase
    endfunction : cyc_of
    // One calibration, with an ignored second start in mid-run
    task automatic run(input logic [1:0] c, input logic d, input logic f, input logic [3:0] ls);
        @(posedge ref_clk);
        cal_wait <= c;
        cal_dual <= d;
        freq_select <= f;
        vco_voltage_target <= vt;
        lock_select <= ls;
        @(posedge ref_clk);
        cal_start <= 1'b1;
        exp_q.push_back('{cyc_of(c), {1'b0, vt} + 4'h3, ls == pll_cal_pkg::LOCK_SRC_CAL_DONE});
        repeat (3) @(posedge ref_clk);
        @(negedge ref_clk);
        chk("busy at start", cal_busy, 1);
        chk("done at start", cal_done, 0);
        @(posedge ref_clk);
        cal_start <= 1'b0;
        repeat (5) @(posedge ref_clk);
        cal_start <= 1'b1;
        repeat (4) @(posedge ref_clk);
        cal_start <= 1'b0;
        for (i = 0; i < 400 && cal_done !== 1'b1; i++) @(negedge ref_clk);
        repeat (3) @(posedge ref_clk);
    endtask : run
    ////////////////////////////////////////////////////////////////////////
    // Serial select is host side only; no pin here to hold high
    // Clock and hang guard
    initial
    begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            err_count++;
            print_verdict();
        end
    end
    // Result watcher: takes the oldest note when a run completes
    always @(posedge ref_clk)
    begin
        if (pend)
        begin
            pend = 1'b0;
            chk("pump code", pump_current_code, e.pump);
            chk("status", second_status_reg, {4'h0, e.pump});
            chk("lock pin done", lock_pin, e.lpin);
        end
        if (cal_done === 1'b1 && done_q !== 1'b1)
        begin
            if (exp_q.size() > 0)
            begin
                e = exp_q.pop_front();
                chk("run length", busy_cnt, e.cyc);
                pend = 1'b1;
            end
            else
                chk("unexpected done", 1, 0);
        end
        busy_cnt = (cal_busy === 1'b1) ? busy_cnt + 1 : 0;
        done_q = cal_done;
    end
    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        void'($urandom(32'h667f_ce03));
        {rst, soft_reset_n, cal_start, cal_dual, freq_select, pend, done_q} = 7'h40;
        {rx_power_en, tx_power_en, synth_power_en, xosc_power_en} = 4'h0;
        {cal_wait, vco_voltage_target, lock_select} = 9'h000;
        {osc_bias_first, osc_bias_second} = 8'h00;
        repeat (4) @(posedge ref_clk);
        @(negedge ref_clk);
        chk("reset done", {cal_done, cal_busy, lock_pin, pll_locked_flag}, 0);
        chk("reset pump", pump_current_code, pll_cal_pkg::PUMP_RESET);
        @(posedge ref_clk);
        rst <= 1'b0;
        soft_reset_n <= 1'b1;
        for (w = 0; w < 8; w++)
        begin
            @(posedge ref_clk);
            {rx_power_en, tx_power_en, synth_power_en, xosc_power_en} <= 4'($urandom);
            {osc_bias_first, osc_bias_second} <= 8'($urandom);
            freq_select <= 1'($urandom);
            vco_voltage_target <= 3'($urandom);
            @(negedge ref_clk);
            chk("power", {rx_on, tx_on, synth_on, xosc_on},
                {rx_power_en, tx_power_en, synth_power_en, xosc_power_en});
            chk("bias", osc_bias, freq_select ? osc_bias_second : osc_bias_first);
            chk("vtarget", cal_vtarget, vco_voltage_target);
        end
        @(posedge ref_clk);
        {rx_power_en, tx_power_en, synth_power_en, xosc_power_en} <= 4'h0;
        for (w = 0; w < 4; w++)
        begin
            vt = 3'($urandom);
            run(w[1:0], 1'b1, 1'b0, w[0] ? 4'h5 : 4'h7);
        end
        last_pump = {1'b0, vt} + 4'h3;
        @(posedge ref_clk);
        freq_select <= 1'b1;
        repeat (3) @(negedge ref_clk);
        chk("dual shared", pump_current_code, last_pump);
        vt = vt + 3'h1;
        run(2'h3, 1'b0, 1'b1, 4'h5);
        @(posedge ref_clk);
        freq_select <= 1'b0;
        repeat (3) @(negedge ref_clk);
        chk("first kept", pump_current_code, last_pump);
        // Soft reset in mid-run aborts but keeps results
        @(posedge ref_clk);
        cal_start <= 1'b1;
        xosc_power_en <= 1'b1;
        repeat (20) @(posedge ref_clk);
        soft_reset_n <= 1'b0;
        cal_start <= 1'b0;
        repeat (3) @(negedge ref_clk);
        chk("soft abort", {cal_busy, cal_done, xosc_on}, 0);
        @(posedge ref_clk);
        soft_reset_n <= 1'b1;
        repeat (3) @(negedge ref_clk);
        chk("soft kept", pump_current_code, last_pump);
        // Lock flag delay and lock pin source
        @(posedge ref_clk);
        lock_select <= pll_cal_pkg::LOCK_SRC_LOCKED;
        synth_power_en <= 1'b1;
        for (i = 0; i < 100 && pll_lock_raw !== 1'b1; i++) @(negedge ref_clk);
        n = 0;
        while (pll_locked_flag !== 1'b1 && n < 20)
        begin
            @(negedge ref_clk);
            n++;
        end
        chk("lock delay", n, pll_cal_pkg::LOCK_FILT_CYC + 2);
        @(negedge ref_clk);
        chk("lock pin", lock_pin, 1);
        chk("notes left", exp_q.size(), 0);
        print_verdict();
    end
endmodule : pll_calibration_power_sequencer_tb
`default_nettype wire
